// ===== ifls_params.svh
// constants for the input fault live status register bank
`ifndef IFLS_PARAMS_SVH
`define IFLS_PARAMS_SVH

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define IFLS_ADDR_SUMMARY 8'h2d
`define IFLS_ADDR_CH_ONE  8'h2e
`define IFLS_ADDR_CH_TWO  8'h2f

// --------------------------------------------------------------
// reset and fill values
// --------------------------------------------------------------
`define IFLS_RESET_BYTE   8'h00
`define IFLS_UNMAPPED     8'h00

// --------------------------------------------------------------
// summary register field positions
// --------------------------------------------------------------
`define IFLS_SUM_CH_ONE   7
`define IFLS_SUM_CH_TWO   6
`define IFLS_SUM_BATT_LOW 1
`define IFLS_SUM_USED     8'hc2

// --------------------------------------------------------------
// synchroniser latency (cycles from pin to live bit)
// --------------------------------------------------------------
`define IFLS_SYNC_LAT     4

`endif

// ===== ifls_pkg.sv
// types for the input fault live status register bank
package ifls_pkg;

    // one channel's live fault bits, msb first as in the register
    typedef struct packed {
        logic open_input;
        logic pair_short;
        logic pos_gnd;
        logic neg_gnd;
        logic pos_supply;
        logic neg_supply;
        logic pos_batt;
        logic neg_batt;
    } ifls_chan_fault_t;

    // everything sensed by the analog detectors
    typedef struct packed {
        ifls_chan_fault_t ch_one;
        ifls_chan_fault_t ch_two;
        logic             batt_low;
    } ifls_sense_t;

    // register port request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ifls_req_t;

    // register port answer
    typedef struct packed {
        logic       rvalid;
        logic [7:0] rdata;
        logic       wr_refused;
    } ifls_resp_t;

    // whole module state
    typedef struct packed {
        ifls_sense_t s1;
        ifls_sense_t s2;
        ifls_sense_t s3;
        ifls_sense_t live;
        ifls_resp_t  resp;
    } ifls_state_t;

endpackage

// ===== ifls_input_fault_live_status.sv
// live fault status registers for the two input channels
//
// Functional notes
// - summary bit 7 is one while any channel one fault exists.
// - summary bit 6 is one while any channel two fault exists.
// - summary bit 1 flags battery short while battery below mic supply.
// - reserved bits read zero; software writes only zero there.
// - channel one register at 0x2e; bit 7 is open input.
// - channel one bit 6 flags the input pair shorted together.
// - channel one bits 5 and 4 flag ground shorts, positive, negative.
// - channel one bits 3 and 2 flag mic supply shorts.
// - channel one bits 1 and 0 flag battery shorts.
// - channel two register at 0x2f; bit 7 is open input.
// - channel two bit 6 flags the input pair shorted together.
// - channel two bits 5 and 4 flag ground shorts, positive, negative.
// - channel two bits 3 and 2 flag mic supply shorts.
// - channel two bits 1 and 0 flag battery shorts.
// - channel bits are read only, zero after reset, writes ignored.
// - channel bits are live, clearing once the condition goes away.
// - summary register at 0x2d, zero after reset.
`timescale 1ns/1ps
`include "ifls_params.svh"

module ifls_input_fault_live_status
    import ifls_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire ifls_chan_fault_t ch_one_fault_raw,
    input  wire ifls_chan_fault_t ch_two_fault_raw,
    input  wire logic             batt_low_raw,
    input  wire ifls_req_t        reg_req,
    output ifls_resp_t            reg_resp
);

    // --------------------------------------------------------------
    // helper functions
    // --------------------------------------------------------------

    // any fault at all on one channel
    function automatic logic chan_any(input ifls_chan_fault_t f);
        chan_any = |f;
    endfunction

    // either pin of one channel shorted to the battery
    function automatic logic chan_batt(input ifls_chan_fault_t f);
        chan_batt = f.pos_batt | f.neg_batt;
    endfunction

    // build the summary byte from the live channel bits
    function automatic logic [7:0] summary_of(input ifls_sense_t s);
        logic [7:0] v;
        v = `IFLS_RESET_BYTE;
        v[`IFLS_SUM_CH_ONE] = chan_any(s.ch_one);
        v[`IFLS_SUM_CH_TWO] = chan_any(s.ch_two);
        v[`IFLS_SUM_BATT_LOW] = s.batt_low
            & (chan_batt(s.ch_one) | chan_batt(s.ch_two));
        summary_of = v;
    endfunction

    // per bit filter: take the new level only where stages agree
    function automatic ifls_sense_t settle(
        input ifls_sense_t old_v,
        input ifls_sense_t mid_v,
        input ifls_sense_t late_v
    );
        ifls_sense_t diff;
        diff = mid_v ^ late_v;
        settle = (mid_v & ~diff) | (old_v & diff);
    endfunction

    // --------------------------------------------------------------
    // state and next state
    // --------------------------------------------------------------
    ifls_state_t state;
    ifls_state_t next_state;
    ifls_sense_t sense_raw;
    logic [7:0]  summary_live;

    // gather the detector pins into one vector
    assign sense_raw.ch_one   = ch_one_fault_raw;
    assign sense_raw.ch_two   = ch_two_fault_raw;
    assign sense_raw.batt_low = batt_low_raw;

    // summary bits follow the live channel bits directly
    assign summary_live = summary_of(state.live);

    // register port answer straight from flops
    assign reg_resp = state.resp;

    // --------------------------------------------------------------
    // next state logic
    // --------------------------------------------------------------

    // synchronise, filter, and answer register requests
    always_comb begin
        next_state = state;

        // three stage synchroniser, first stage feeds only the second
        next_state.s1 = sense_raw;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;

        // live bits follow the pins, no latching
        next_state.live = settle(state.live, state.s2, state.s3);

        // answer defaults: no read data strobe, no refusal
        next_state.resp.rvalid     = 1'b0;
        next_state.resp.wr_refused = 1'b0;

        // reads: one cycle later, data with rvalid
        if (reg_req.rd) begin
            next_state.resp.rvalid = 1'b1;
            case (reg_req.addr)
                `IFLS_ADDR_SUMMARY: begin
                    // unused summary bits stay zero
                    next_state.resp.rdata = summary_live;
                end
                `IFLS_ADDR_CH_ONE: begin
                    // open, pair, ground, supply, battery bits
                    next_state.resp.rdata = state.live.ch_one;
                end
                `IFLS_ADDR_CH_TWO: begin
                    // same layout for the second channel
                    next_state.resp.rdata = state.live.ch_two;
                end
                default: begin
                    next_state.resp.rdata = `IFLS_UNMAPPED;
                end
            endcase
        end

        // writes never change a status bit; flag them as refused
        if (reg_req.wr) begin
            next_state.resp.wr_refused = 1'b1;
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------

    // everything clears on reset, so every bit reads zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking ast_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // summary read: bit 7 ties to channel one faults
    AST_SUM_CH_ONE:
        assert property (
            reg_req.rd && reg_req.addr == `IFLS_ADDR_SUMMARY
            |=> reg_resp.rvalid
                && reg_resp.rdata[`IFLS_SUM_CH_ONE]
                   == $past(|state.live.ch_one)
        ) else $error("summary ch one bit wrong");

    // summary read: bit 6 ties to channel two faults
    AST_SUM_CH_TWO:
        assert property (
            reg_req.rd && reg_req.addr == `IFLS_ADDR_SUMMARY
            |=> reg_resp.rdata[`IFLS_SUM_CH_TWO]
                == $past(|state.live.ch_two)
        ) else $error("summary ch two bit wrong");

    // summary battery bit needs both a battery short and low battery
    AST_SUM_BATT:
        assert property (
            summary_live[`IFLS_SUM_BATT_LOW]
            == (state.live.batt_low
                && (state.live.ch_one.pos_batt || state.live.ch_one.neg_batt
                    || state.live.ch_two.pos_batt
                    || state.live.ch_two.neg_batt))
        ) else $error("summary battery bit wrong");

    // reserved summary bits read zero
    AST_SUM_RESERVED:
        assert property (
            reg_req.rd && reg_req.addr == `IFLS_ADDR_SUMMARY
            |=> (reg_resp.rdata & ~`IFLS_SUM_USED) == `IFLS_RESET_BYTE
        ) else $error("reserved summary bit set");

    // channel one read returns the live bits of the cycle before
    AST_CH_ONE_READ:
        assert property (
            reg_req.rd && reg_req.addr == `IFLS_ADDR_CH_ONE
            |=> reg_resp.rvalid && reg_resp.rdata == $past(state.live.ch_one)
        ) else $error("channel one read wrong");

    // channel two read returns the live bits of the cycle before
    AST_CH_TWO_READ:
        assert property (
            reg_req.rd && reg_req.addr == `IFLS_ADDR_CH_TWO
            |=> reg_resp.rvalid && reg_resp.rdata == $past(state.live.ch_two)
        ) else $error("channel two read wrong");

    // a pin level held four cycles shows in the live bits
    AST_LIVE_FOLLOWS:
        assert property (
            $stable(sense_raw) [*4]
            |-> state.live == sense_raw
        ) else $error("live bits do not follow pins");

    // a one cycle glitch never reaches the live bits
    AST_GLITCH_BLOCKED:
        assert property (
            $stable(state.s3) && $stable(state.live) && state.s2 != state.s3
            ##1 state.s2 == $past(state.s3)
            |-> $stable(state.live)
        ) else $error("glitch reached live bits");

    // a write alone never yields read data
    AST_WRITE_NO_READ:
        assert property (
            reg_req.wr && !reg_req.rd
            |=> reg_resp.wr_refused && !reg_resp.rvalid
        ) else $error("write produced read data");

    // unmapped reads return zero
    AST_UNMAPPED_ZERO:
        assert property (
            reg_req.rd && reg_req.addr != `IFLS_ADDR_SUMMARY
            && reg_req.addr != `IFLS_ADDR_CH_ONE
            && reg_req.addr != `IFLS_ADDR_CH_TWO
            |=> reg_resp.rdata == `IFLS_UNMAPPED
        ) else $error("unmapped read not zero");

    // after reset release every live bit reads zero
    AST_RESET_CLEAR:
        assert property (
            $rose(rst_n) |-> state.live == '0 && summary_live == `IFLS_RESET_BYTE
        ) else $error("state not clear after reset");

    // a read and a write together are both answered
    AST_RD_WR_BOTH:
        assert property (
            reg_req.rd && reg_req.wr
            |=> reg_resp.rvalid && reg_resp.wr_refused
        ) else $error("joint request not answered");

    // no read strobe without a read request
    AST_RVALID_PULSE:
        assert property (
            !reg_req.rd
            |=> !reg_resp.rvalid
        ) else $error("read strobe without request");

    // summary channel bits are the OR of the live channel bits
    AST_SUM_IS_OR:
        assert property (
            summary_live[`IFLS_SUM_CH_ONE] == (state.live.ch_one != '0)
            && summary_live[`IFLS_SUM_CH_TWO] == (state.live.ch_two != '0)
        ) else $error("summary OR wrong");

    // --------------------------------------------------------------
    // per field checks from detector pin to live bit
    // --------------------------------------------------------------

    // channel one open input follows its pin
    AST_CH_ONE_OPEN:
        assert property (
            $stable(ch_one_fault_raw.open_input) [*4]
            |-> state.live.ch_one.open_input == ch_one_fault_raw.open_input
        ) else $error("channel one open bit wrong");

    // channel one pair short follows its pin
    AST_CH_ONE_PAIR:
        assert property (
            $stable(ch_one_fault_raw.pair_short) [*4]
            |-> state.live.ch_one.pair_short == ch_one_fault_raw.pair_short
        ) else $error("channel one pair bit wrong");

    // channel one ground shorts follow their pins
    AST_CH_ONE_GND:
        assert property (
            $stable({ch_one_fault_raw.pos_gnd, ch_one_fault_raw.neg_gnd}) [*4]
            |-> {state.live.ch_one.pos_gnd, state.live.ch_one.neg_gnd}
                == {ch_one_fault_raw.pos_gnd, ch_one_fault_raw.neg_gnd}
        ) else $error("channel one ground bits wrong");

    // channel one supply shorts follow their pins
    AST_CH_ONE_SUPPLY:
        assert property (
            $stable({ch_one_fault_raw.pos_supply, ch_one_fault_raw.neg_supply}) [*4]
            |-> {state.live.ch_one.pos_supply, state.live.ch_one.neg_supply}
                == {ch_one_fault_raw.pos_supply, ch_one_fault_raw.neg_supply}
        ) else $error("channel one supply bits wrong");

    // channel one battery shorts follow their pins
    AST_CH_ONE_BATT:
        assert property (
            $stable({ch_one_fault_raw.pos_batt, ch_one_fault_raw.neg_batt}) [*4]
            |-> {state.live.ch_one.pos_batt, state.live.ch_one.neg_batt}
                == {ch_one_fault_raw.pos_batt, ch_one_fault_raw.neg_batt}
        ) else $error("channel one battery bits wrong");

    // channel two open input follows its pin
    AST_CH_TWO_OPEN:
        assert property (
            $stable(ch_two_fault_raw.open_input) [*4]
            |-> state.live.ch_two.open_input == ch_two_fault_raw.open_input
        ) else $error("channel two open bit wrong");

    // channel two pair short follows its pin
    AST_CH_TWO_PAIR:
        assert property (
            $stable(ch_two_fault_raw.pair_short) [*4]
            |-> state.live.ch_two.pair_short == ch_two_fault_raw.pair_short
        ) else $error("channel two pair bit wrong");

    // channel two ground shorts follow their pins
    AST_CH_TWO_GND:
        assert property (
            $stable({ch_two_fault_raw.pos_gnd, ch_two_fault_raw.neg_gnd}) [*4]
            |-> {state.live.ch_two.pos_gnd, state.live.ch_two.neg_gnd}
                == {ch_two_fault_raw.pos_gnd, ch_two_fault_raw.neg_gnd}
        ) else $error("channel two ground bits wrong");

    // channel two supply shorts follow their pins
    AST_CH_TWO_SUPPLY:
        assert property (
            $stable({ch_two_fault_raw.pos_supply, ch_two_fault_raw.neg_supply}) [*4]
            |-> {state.live.ch_two.pos_supply, state.live.ch_two.neg_supply}
                == {ch_two_fault_raw.pos_supply, ch_two_fault_raw.neg_supply}
        ) else $error("channel two supply bits wrong");

    // channel two battery shorts follow their pins
    AST_CH_TWO_BATT:
        assert property (
            $stable({ch_two_fault_raw.pos_batt, ch_two_fault_raw.neg_batt}) [*4]
            |-> {state.live.ch_two.pos_batt, state.live.ch_two.neg_batt}
                == {ch_two_fault_raw.pos_batt, ch_two_fault_raw.neg_batt}
        ) else $error("channel two battery bits wrong");

endmodule

// ===== test_input_fault_live_status.sv
// self-checking bench for the input fault live status registers
`timescale 1ns/1ps
module test_input_fault_live_status
    import ifls_pkg::*;
;
    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    logic             ref_clk;
    logic             rst_n;
    logic             batt_low_raw;
    ifls_chan_fault_t ch_one_fault_raw;
    ifls_chan_fault_t ch_two_fault_raw;
    ifls_req_t        reg_req;
    ifls_resp_t       reg_resp;
    int               mismatches;
    int               n_compared;
    int               i;
    logic [7:0]       c;

    ifls_input_fault_live_status u_dut (
        .ref_clk          (ref_clk),
        .rst_n            (rst_n),
        .ch_one_fault_raw (ch_one_fault_raw),
        .ch_two_fault_raw (ch_two_fault_raw),
        .batt_low_raw     (batt_low_raw),
        .reg_req          (reg_req),
        .reg_resp         (reg_resp)
    );

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one read, bounded wait for the answer, then compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        int k;
        @(posedge ref_clk);
        reg_req.rd   <= 1'b1;
        reg_req.addr <= a;
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
        #1;
        for (k = 0; k < 4 && reg_resp.rvalid !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        if (reg_resp.rvalid !== 1'b1) begin
            check({7'h0, reg_resp.rvalid}, 8'h01);
            stop_test();
        end else begin
            check(reg_resp.rdata, exp);
        end
    endtask

    // one write, refusal pulse expected one cycle later
    task automatic wr_chk(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req.wr    <= 1'b1;
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
        #1;
        check({7'h0, reg_resp.wr_refused}, 8'h01);
    endtask

    // drive detector levels and let them settle through the synchroniser
    task automatic apply(input logic [7:0] c1, input logic [7:0] c2, input logic bl);
        @(posedge ref_clk);
        ch_one_fault_raw <= c1;
        ch_two_fault_raw <= c2;
        batt_low_raw     <= bl;
        repeat (6) @(posedge ref_clk);
    endtask

    // expected summary byte
    function automatic logic [7:0] sum_exp(logic [7:0] c1, logic [7:0] c2, logic bl);
        return {|c1, |c2, 4'h0, bl & (c1[1] | c1[0] | c2[1] | c2[0]), 1'h0};
    endfunction

    // read all three registers against the expected picture
    task automatic chk_all(input logic [7:0] c1, input logic [7:0] c2, input logic bl);
        rd_chk(8'h2e, c1);
        rd_chk(8'h2f, c2);
        rd_chk(8'h2d, sum_exp(c1, c2, bl));
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        mismatches       = 0;
        n_compared       = 0;
        rst_n            = 1'b0;
        batt_low_raw     = 1'b0;
        ch_one_fault_raw = '0;
        ch_two_fault_raw = '0;
        reg_req          = '0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;

        // reset values and an unmapped place
        rd_chk(8'h2d, 8'h00);
        rd_chk(8'h2e, 8'h00);
        rd_chk(8'h2f, 8'h00);
        rd_chk(8'h30, 8'h00);
        $display("test reset_values done");

        // walk one fault bit through each channel, battery low set for channel one, both ways for channel two
        for (i = 0; i < 8; i++) begin
            c = 8'h01 << i;
            apply(c, 8'h00, 1'b1);
            chk_all(c, 8'h00, 1'b1);
            apply(8'h00, c, 1'b0);
            chk_all(8'h00, c, 1'b0);
            apply(8'h00, c, 1'b1);
            chk_all(8'h00, c, 1'b1);
        end
        $display("test bit_walk done");

        // all faults, then every channel fault gone again, battery low still set
        apply(8'hff, 8'hff, 1'b1);
        chk_all(8'hff, 8'hff, 1'b1);
        apply(8'h00, 8'h00, 1'b1);
        chk_all(8'h00, 8'h00, 1'b1);
        $display("test live_clear done");

        // one cycle pulse on every channel fault pin is filtered out
        @(posedge ref_clk);
        ch_one_fault_raw <= 8'hff;
        ch_two_fault_raw <= 8'hff;
        @(posedge ref_clk);
        ch_one_fault_raw <= 8'h00;
        ch_two_fault_raw <= 8'h00;
        repeat (6) @(posedge ref_clk);
        chk_all(8'h00, 8'h00, 1'b1);
        $display("test glitch_filter done");

        // writes refused, contents unchanged
        apply(8'h55, 8'haa, 1'b1);
        wr_chk(8'h2d, 8'h00);
        wr_chk(8'h2e, 8'hff);
        wr_chk(8'h2f, 8'h00);
        chk_all(8'h55, 8'haa, 1'b1);
        $display("test write_refused done");

        stop_test();
    end
endmodule
